// *** hdl/tlic_regs.svh ***
// What this block does
// RL1 - High level vectors 000008h, low level 000018h
// RL2 - High request preempts low service, never reverse
// RL3 - Sources have flag, enable, priority; pin zero none
// RL4 - Priority scheme only while enable bit set
// RL5 - High global enable admits priority-set sources
// RL6 - Low global enable admits priority-clear sources
// RL7 - Flag, enable, global enable vector; enable blocks
// RL8 - Compatibility mode ignores priority bits
// RL9 - Compatibility: bit 6 peripheral, bit 7 global
// RL10 - Compatibility mode always vectors to 000008h
// RL11 - Acceptance clears the admitting global enable
// RL12 - Core pushes return address, loads vector
// RL13 - Routine polls and clears flags before re-enable
// RL14 - Return instruction sets the right global enable
// RL15 - Event to vector takes three to four cycles
// RL16 - Flags set on event regardless of enables
// RL17 - No memory-to-memory move on enabled control registers
// RL18 - Low global enable gates low peripheral sources
// RL19 - Simultaneous requests: high first, low stays pending
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH

// Register offsets on the register port
`define TLIC_OFF_CTRL 4'h0
`define TLIC_OFF_RSTCTL 4'h1
`define TLIC_OFF_FLAG 4'h2
`define TLIC_OFF_ENABLE 4'h3
`define TLIC_OFF_PRIO 4'h4
`define TLIC_OFF_SERVICE 4'h5
`define TLIC_OFF_ISTAT 4'h6
`define TLIC_OFF_IMASK 4'h7

// Field positions
`define TLIC_BIT_GLB_HIGH 7
`define TLIC_BIT_GLB_LOW 6
`define TLIC_BIT_PRIO_SCHEME 7
`define TLIC_BIT_EV_HIGH 0
`define TLIC_BIT_EV_LOW 1
`define TLIC_BIT_EV_RET 2

// Source groups: bit 0 is external pin zero, upper nibble peripherals
`define TLIC_PIN0_MASK 8'h01
`define TLIC_CORE_MASK 8'h0F
`define TLIC_PERIPH_MASK 8'hF0

// Reset values
`define TLIC_RST_BYTE 8'h00
`define TLIC_RST_PRIO 8'hFF
`define TLIC_RST_EV 3'h0

// Vector addresses
`define TLIC_VEC_HIGH 21'h00_0008
`define TLIC_VEC_LOW 21'h00_0018

// Event to vector latency in instruction cycles
`define TLIC_LAT_CYC 3
`define TLIC_WAIT_LOAD (`TLIC_LAT_CYC - 3)

`endif

// *** hdl/tlic_pkg.sv ***
package tlic_pkg;

  // Request sequencing phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT,
    PH_OFFER
  } tlic_phase_type;

  // Whole controller state
  typedef struct packed {
    logic [7:0] flag;
    logic [7:0] enable;
    logic [7:0] prio;
    logic highLevelGlobalEnable;
    logic lowLevelGlobalEnable;
    logic priorityScheme;
    logic inServHigh;
    logic inServLow;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    tlic_phase_type phase;
    logic [1:0] waitCnt;
    logic vecValid;
    logic vecHigh;
    logic [20:0] vecAddr;
    logic [7:0] rdata;
  } tlic_state_type;

endpackage

// *** hdl/tlic_ctrl.sv ***
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tlic_regs.svh"

module tlic_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [7:0] srcEvent,
  output logic vecValid,
  output logic vecHigh,
  output logic [20:0] vecAddr,
  input wire logic coreAck,
  input wire logic returnFromInterruptInstr,
  output logic irqOut
);

  tlic_pkg::tlic_state_type stateReg;
  tlic_pkg::tlic_state_type stateNext;
  logic hiReq;
  logic loReq;
  logic anyReq;
  logic [7:0] pendEn;
  logic [7:0] prioEff;

  // Address match used by the write decode and the status read clear
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // Request decode from registered flags, enables and mode
  always_comb
  begin
    prioEff = stateReg.prio | `TLIC_PIN0_MASK; // RL3
    pendEn = stateReg.flag & stateReg.enable; // RL7
    if (stateReg.priorityScheme) // RL4
    begin
      hiReq = stateReg.highLevelGlobalEnable && |(pendEn & prioEff); // RL5
      // Low requests wait out any high routine, whatever the enables say
      loReq = stateReg.highLevelGlobalEnable && stateReg.lowLevelGlobalEnable
        && !stateReg.inServHigh && |(pendEn & ~prioEff); // RL6 RL18 RL2
    end
    else
    begin
      // Priority bits ignored; peripheral group needs bit 6 as well
      hiReq = stateReg.highLevelGlobalEnable && |(pendEn & (`TLIC_CORE_MASK
        | (`TLIC_PERIPH_MASK & {8{stateReg.lowLevelGlobalEnable}}))); // RL8 RL9
      loReq = 1'b0; // RL8
    end
    anyReq = hiReq || loReq;
  end

  // Next-state logic
  always_comb
  begin
    stateNext = stateReg;
    // Software writes
    if (regWrite)
    begin
      if (hit(regAddr, `TLIC_OFF_CTRL))
      begin
        stateNext.highLevelGlobalEnable = regWdata[`TLIC_BIT_GLB_HIGH];
        stateNext.lowLevelGlobalEnable = regWdata[`TLIC_BIT_GLB_LOW];
      end
      if (hit(regAddr, `TLIC_OFF_RSTCTL))
        stateNext.priorityScheme = regWdata[`TLIC_BIT_PRIO_SCHEME]; // RL4
      if (hit(regAddr, `TLIC_OFF_FLAG))
        stateNext.flag = regWdata;
      if (hit(regAddr, `TLIC_OFF_ENABLE))
        stateNext.enable = regWdata;
      if (hit(regAddr, `TLIC_OFF_PRIO))
        stateNext.prio = regWdata | `TLIC_PIN0_MASK; // RL3
      if (hit(regAddr, `TLIC_OFF_IMASK))
        stateNext.irqMask = regWdata[2:0];
    end
    // Events set flags whatever the enables; set beats a clear
    stateNext.flag = stateNext.flag | srcEvent; // RL16
    // Reading interrupt status clears it before new events land
    if (regRead && hit(regAddr, `TLIC_OFF_ISTAT))
      stateNext.irqStat = `TLIC_RST_EV;

    // Vector request sequencing
    case (stateReg.phase)
      tlic_pkg::PH_IDLE:
      begin
        if (anyReq)
        begin
          stateNext.phase = tlic_pkg::PH_WAIT;
          stateNext.waitCnt = 2'(`TLIC_WAIT_LOAD); // RL15
        end
      end
      tlic_pkg::PH_WAIT:
      begin
        if (!anyReq)
          stateNext.phase = tlic_pkg::PH_IDLE; // RL7
        else if (stateReg.waitCnt == 2'h0)
        begin
          stateNext.phase = tlic_pkg::PH_OFFER; // RL15
          stateNext.vecValid = 1'b1;
          stateNext.vecHigh = hiReq; // RL19
          stateNext.vecAddr = hiReq ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW; // RL1 RL10
        end
        else
          stateNext.waitCnt = stateReg.waitCnt - 2'h1;
      end
      tlic_pkg::PH_OFFER:
      begin
        if (coreAck)
        begin
          // Core pushes return address and jumps; admitting enable drops
          stateNext.phase = tlic_pkg::PH_IDLE; // RL12
          stateNext.vecValid = 1'b0;
          if (stateReg.vecHigh)
          begin
            stateNext.highLevelGlobalEnable = 1'b0; // RL11
            stateNext.inServHigh = 1'b1;
            stateNext.irqStat[`TLIC_BIT_EV_HIGH] = 1'b1;
          end
          else
          begin
            stateNext.lowLevelGlobalEnable = 1'b0; // RL11
            stateNext.inServLow = 1'b1;
            stateNext.irqStat[`TLIC_BIT_EV_LOW] = 1'b1;
          end
        end
        else if (!anyReq)
        begin
          // Request withdrawn by software before the core took it
          stateNext.phase = tlic_pkg::PH_IDLE; // RL7
          stateNext.vecValid = 1'b0;
        end
        else
        begin
          // A high request overtakes a waiting low one
          stateNext.vecHigh = hiReq; // RL19 RL2
          stateNext.vecAddr = hiReq ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW; // RL1
        end
      end
      default:
      begin
        stateNext.phase = tlic_pkg::PH_IDLE;
        stateNext.vecValid = 1'b0;
      end
    endcase

    // Return restores the enable of the level being left
    if (returnFromInterruptInstr)
    begin
      stateNext.irqStat[`TLIC_BIT_EV_RET] = 1'b1;
      if (!stateReg.priorityScheme || stateReg.inServHigh)
      begin
        stateNext.highLevelGlobalEnable = 1'b1; // RL14
        stateNext.inServHigh = 1'b0;
      end
      else
      begin
        stateNext.lowLevelGlobalEnable = 1'b1; // RL14
        stateNext.inServLow = 1'b0;
      end
    end

    // Read data, one cycle after the strobe
    stateNext.rdata = 8'h00;
    if (regRead)
    begin
      case (regAddr)
        `TLIC_OFF_CTRL:
          stateNext.rdata = {stateReg.highLevelGlobalEnable,
            stateReg.lowLevelGlobalEnable, 6'h00};
        `TLIC_OFF_RSTCTL:
          stateNext.rdata = {stateReg.priorityScheme, 7'h00};
        `TLIC_OFF_FLAG:
          stateNext.rdata = stateReg.flag;
        `TLIC_OFF_ENABLE:
          stateNext.rdata = stateReg.enable;
        `TLIC_OFF_PRIO:
          stateNext.rdata = stateReg.prio;
        `TLIC_OFF_SERVICE:
          stateNext.rdata = {6'h00, stateReg.inServLow, stateReg.inServHigh};
        `TLIC_OFF_ISTAT:
          stateNext.rdata = {5'h00, stateReg.irqStat};
        `TLIC_OFF_IMASK:
          stateNext.rdata = {5'h00, stateReg.irqMask};
        default:
          stateNext.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stateReg.flag <= `TLIC_RST_BYTE;
      stateReg.enable <= `TLIC_RST_BYTE;
      stateReg.prio <= `TLIC_RST_PRIO;
      stateReg.highLevelGlobalEnable <= 1'b0;
      stateReg.lowLevelGlobalEnable <= 1'b0;
      stateReg.priorityScheme <= 1'b0; // RL4
      stateReg.inServHigh <= 1'b0;
      stateReg.inServLow <= 1'b0;
      stateReg.irqStat <= `TLIC_RST_EV;
      stateReg.irqMask <= `TLIC_RST_EV;
      stateReg.phase <= tlic_pkg::PH_IDLE;
      stateReg.waitCnt <= 2'h0;
      stateReg.vecValid <= 1'b0;
      stateReg.vecHigh <= 1'b0;
      stateReg.vecAddr <= `TLIC_VEC_HIGH;
      stateReg.rdata <= 8'h00;
    end
    else
      stateReg <= stateNext;
  end

  // Outputs
  assign regRdata = stateReg.rdata;
  assign vecValid = stateReg.vecValid;
  assign vecHigh = stateReg.vecHigh;
  assign vecAddr = stateReg.vecAddr;
  assign irqOut = |(stateReg.irqStat & stateReg.irqMask);

  // Every property runs on the instruction clock and rests during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Eligible request seen while idle, still eligible a cycle later
  sequence seqReqStart;
    (stateReg.phase == tlic_pkg::PH_IDLE) && anyReq ##1 anyReq;
  endsequence

  // High level offer taken by the core
  sequence seqHighTaken;
    stateReg.vecValid && coreAck && stateReg.vecHigh;
  endsequence

  // Low level offer taken by the core
  sequence seqLowTaken;
    stateReg.vecValid && coreAck && !stateReg.vecHigh;
  endsequence

  // High request arising while only a low routine runs
  sequence seqHighDuringLow;
    stateReg.priorityScheme && stateReg.inServLow && !stateReg.inServHigh
      && (stateReg.phase == tlic_pkg::PH_IDLE) && hiReq ##1 hiReq;
  endsequence

  // Vector on offer that the core has not yet taken
  sequence seqOfferOpen;
    stateReg.vecValid && !coreAck;
  endsequence

  // Events land in their flags at once
  a_flag_on_event: assert property ((|srcEvent) // RL16
    |=> ((stateReg.flag & $past(srcEvent)) == $past(srcEvent)))
    else $error("event did not set its flag");

  // Flags only drop through a software write
  a_flag_sticky: assert property (!(regWrite && regAddr == `TLIC_OFF_FLAG) // RL16
    |=> (stateReg.flag & $past(stateReg.flag)) == $past(stateReg.flag))
    else $error("flag lost without a write");

  // A request that stays eligible is offered two edges after it starts
  a_vector_latency: assert property (seqReqStart // RL15
    |=> stateReg.vecValid)
    else $error("vector not offered in time");

  // Compatibility mode only ever offers the high vector
  a_compat_vector: assert property (stateReg.vecValid // RL10 RL8
    && !stateReg.priorityScheme
    |-> stateReg.vecAddr == `TLIC_VEC_HIGH && stateReg.vecHigh)
    else $error("compatibility vector wrong");

  // Offered address always matches the offered level
  a_level_vector: assert property (stateReg.vecValid // RL1
    |-> stateReg.vecAddr == (stateReg.vecHigh ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW))
    else $error("vector address does not match level");

  // Taking a high vector drops the high enable and marks high service
  a_high_clears_gie: assert property (seqHighTaken // RL11
    |=> !stateReg.highLevelGlobalEnable && stateReg.inServHigh && !stateReg.vecValid)
    else $error("high accept wrong");

  // Taking a low vector drops the low enable and marks low service
  a_low_clears_gie: assert property (seqLowTaken // RL11
    |=> !stateReg.lowLevelGlobalEnable && stateReg.inServLow)
    else $error("low accept wrong");

  // A taken high vector leaves its mark in the status register
  a_high_status: assert property (seqHighTaken
    |=> stateReg.irqStat[`TLIC_BIT_EV_HIGH])
    else $error("high accept not flagged");

  // A taken low vector leaves its mark in the status register
  a_low_status: assert property (seqLowTaken
    |=> stateReg.irqStat[`TLIC_BIT_EV_LOW])
    else $error("low accept not flagged");

  // Return in compatibility mode turns the single enable back on
  a_return_enables: assert property (returnFromInterruptInstr // RL14
    && !stateReg.priorityScheme |=> stateReg.highLevelGlobalEnable)
    else $error("return did not re-enable");

  // Return from a high routine in priority mode restores the high enable
  a_return_high: assert property (returnFromInterruptInstr // RL14
    && stateReg.priorityScheme && stateReg.inServHigh
    |=> stateReg.highLevelGlobalEnable && !stateReg.inServHigh)
    else $error("return did not restore high level");

  // Every return is noted in the status register
  a_return_status: assert property (returnFromInterruptInstr
    |=> stateReg.irqStat[`TLIC_BIT_EV_RET])
    else $error("return not flagged");

  // No low request while a high routine runs
  a_no_low_preempt: assert property (stateReg.priorityScheme // RL2
    && stateReg.inServHigh && !returnFromInterruptInstr |=> !loReq)
    else $error("low preempted high");

  // A high request interrupts a running low routine
  a_high_preempts: assert property (seqHighDuringLow // RL2
    |=> stateReg.vecValid && stateReg.vecHigh)
    else $error("high did not preempt low");

  // Sources with a clear enable never request
  a_enable_blocks: assert property ((stateReg.flag & stateReg.enable) == 8'h00 // RL7
    |-> !anyReq)
    else $error("disabled source requested");

  // An eligible offer stands until the core takes it
  a_offer_stands: assert property (seqOfferOpen ##0 anyReq // RL7
    |=> stateReg.vecValid)
    else $error("offer dropped while eligible");

  // An offer whose request went away is withdrawn
  a_offer_withdrawn: assert property (seqOfferOpen ##0 !anyReq // RL7
    |=> !stateReg.vecValid)
    else $error("offer kept after request vanished");

  // A clear high enable silences every source in both modes
  a_high_gie_gates: assert property (!stateReg.highLevelGlobalEnable // RL5 RL9
    |-> !anyReq)
    else $error("request with high enable clear");

  // A clear low enable silences the low level in priority mode
  a_low_gie_gates: assert property (stateReg.priorityScheme // RL6 RL18
    && !stateReg.lowLevelGlobalEnable |-> !loReq)
    else $error("low request with low enable clear");

  // Without the peripheral enable only the core group may request
  a_periph_gate: assert property (!stateReg.priorityScheme // RL9
    && !stateReg.lowLevelGlobalEnable
    && (stateReg.flag & stateReg.enable & `TLIC_CORE_MASK) == 8'h00 |-> !anyReq)
    else $error("peripheral request without its enable");

  // Simultaneous levels: the high vector goes out first
  a_high_first: assert property ((stateReg.phase == tlic_pkg::PH_WAIT) // RL19
    && hiReq && loReq && stateReg.waitCnt == 2'h0 |=> stateReg.vecHigh)
    else $error("low won over high");

  // Read data stand one cycle and are zero otherwise
  a_read_idle: assert property (!regRead
    |=> regRdata == 8'h00)
    else $error("read data not cleared");

  // Reading the status drops the interrupt unless a new event lands
  a_irq_follows: assert property (regRead && regAddr == `TLIC_OFF_ISTAT
    && !returnFromInterruptInstr && !coreAck |=> !irqOut)
    else $error("status not cleared");

endmodule
`default_nettype wire

// *** verification/tlic_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module tlic_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic vecValid,
  input wire logic slow,
  input wire logic doReturn,
  output logic coreAck,
  output logic returnFromInterruptInstr
);
  logic [1:0] waitCnt;

  // Take an offered vector at once or after three cycles
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      coreAck <= 1'b0;
      waitCnt <= 2'h0;
      returnFromInterruptInstr <= 1'b0;
    end
    else
    begin
      returnFromInterruptInstr <= doReturn;
      waitCnt <= (vecValid && !coreAck) ? waitCnt + 2'h1 : 2'h0;
      coreAck <= !coreAck && vecValid && (!slow || waitCnt == 2'h3);
    end
  end
endmodule
`default_nettype wire

// *** verification/test_tlic_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tlic_regs.svh"

module test_tlic_ctrl;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] srcEvent = 8'h00;
  logic slow = 1'b0;
  logic doReturn = 1'b0;
  logic rdPend = 1'b0;
  logic [7:0] regRdata;
  logic [20:0] vecAddr;
  logic vecValid, vecHigh, coreAck, returnFromInterruptInstr, irqOut;
  logic [7:0] expRd[$];
  logic [20:0] expVec[$];
  int mismatches = 0;
  int compares = 0;
  int seed = 32'h0000_607c;
  logic [7:0] rnd;

  // Free running clock
  always #10 core_clk = ~core_clk;

  tlic_ctrl tlic_ctrl_inst (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .srcEvent(srcEvent), .vecValid(vecValid), .vecHigh(vecHigh), .vecAddr(vecAddr),
    .coreAck(coreAck), .returnFromInterruptInstr(returnFromInterruptInstr), .irqOut(irqOut));

  tlic_core_model tlic_core_model_inst (.core_clk(core_clk), .rst(rst), .vecValid(vecValid),
    .slow(slow), .doReturn(doReturn), .coreAck(coreAck),
    .returnFromInterruptInstr(returnFromInterruptInstr));

  task automatic check(input logic [20:0] got, input logic [20:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Match each read answer and each taken vector with the oldest note
  always @(posedge core_clk)
  begin
    rdPend <= regRead;
    if (rdPend)
      check(regRdata, expRd.size() ? expRd.pop_front() : 8'hxx, "read data");
    if (vecValid === 1'b1 && coreAck === 1'b1)
    begin
      check(vecHigh, expVec.size() ? expVec[0] == `TLIC_VEC_HIGH : 1'bx, "level");
      check(vecAddr, expVec.size() ? expVec.pop_front() : 21'h1f_ffff, "vector");
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expRd.push_back(e);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
  endtask

  task automatic fire(input logic [7:0] s);
    @(posedge core_clk);
    srcEvent <= s;
    @(posedge core_clk);
    srcEvent <= 8'h00;
  endtask

  task automatic ret();
    @(posedge core_clk);
    doReturn <= 1'b1;
    @(posedge core_clk);
    doReturn <= 1'b0;
  endtask

  // Bounded wait for the edge at which the core takes a vector
  task automatic waitTaken();
    int i;
    i = 0;
    while (!(vecValid === 1'b1 && coreAck === 1'b1) && i < 12)
    begin
      @(posedge core_clk);
      #1;
      i++;
    end
    if (!(vecValid === 1'b1 && coreAck === 1'b1))
    begin
      mismatches++;
      give_verdict();
    end
    @(posedge core_clk);
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(`TLIC_OFF_RSTCTL, 8'h00);
    rd(`TLIC_OFF_PRIO, 8'hff);
    rnd = 8'($random(seed));
    wr(`TLIC_OFF_ENABLE, rnd);
    rd(`TLIC_OFF_ENABLE, rnd);
    wr(4'h9, 8'h5a);
    rd(4'h9, 8'h00);
    $display("Register test done");
    wr(`TLIC_OFF_ENABLE, 8'h22);
    wr(`TLIC_OFF_IMASK, 8'h01);
    wr(`TLIC_OFF_PRIO, 8'h00);
    rd(`TLIC_OFF_PRIO, 8'h01);
    wr(`TLIC_OFF_CTRL, 8'h80);
    fire(8'h20);
    repeat (6) @(posedge core_clk);
    rd(`TLIC_OFF_FLAG, 8'h20);
    expVec.push_back(`TLIC_VEC_HIGH);
    wr(`TLIC_OFF_CTRL, 8'hc0);
    waitTaken();
    #1 check(irqOut, 1'b1, "irq raised");
    wr(`TLIC_OFF_IMASK, 8'h00);
    #1 check(irqOut, 1'b0, "irq masked");
    rd(`TLIC_OFF_ISTAT, 8'h01);
    wr(`TLIC_OFF_IMASK, 8'h01);
    #1 check(irqOut, 1'b0, "irq cleared");
    rd(`TLIC_OFF_CTRL, 8'h40);
    wr(`TLIC_OFF_FLAG, 8'h00);
    ret();
    rd(`TLIC_OFF_CTRL, 8'hc0);
    $display("Compatibility test done");
    slow <= 1'b1;
    wr(`TLIC_OFF_RSTCTL, 8'h80);
    wr(`TLIC_OFF_PRIO, 8'h0f);
    expVec.push_back(`TLIC_VEC_HIGH);
    expVec.push_back(`TLIC_VEC_LOW);
    fire(8'h22);
    waitTaken();
    rd(`TLIC_OFF_CTRL, 8'h40);
    rd(`TLIC_OFF_SERVICE, 8'h01);
    wr(`TLIC_OFF_FLAG, 8'h20);
    ret();
    waitTaken();
    rd(`TLIC_OFF_CTRL, 8'h80);
    expVec.push_back(`TLIC_VEC_HIGH);
    fire(8'h02);
    waitTaken();
    rd(`TLIC_OFF_SERVICE, 8'h03);
    rd(`TLIC_OFF_CTRL, 8'h00);
    wr(`TLIC_OFF_CTRL, 8'h80);
    wr(`TLIC_OFF_ENABLE, 8'h20);
    repeat (8) @(posedge core_clk);
    check(21'(expVec.size()), 21'h0, "vectors left");
    $display("Priority test done");
    give_verdict();
  end
endmodule
`default_nettype wire
